// File: rtl/osv_pkg.sv
// Constants, types and the register map of the oscillator clock supervisor.
// Assumes a single 200 MHz system clock and an APB master with 32-bit data.
package osv_pkg;

	// Clock and the supervising clock (base rate of the free-running PLL, 5 MHz).
	localparam int         OSV_CLK_PERIOD_NS = 5;
	localparam int         OSV_PLL_HALF_NS   = 100;
	localparam int         OSV_PLL_HALF_CYC  = OSV_PLL_HALF_NS / OSV_CLK_PERIOD_NS;
	localparam int         OSV_DIV_W         = 8;
	localparam logic [7:0] OSV_PLL_HALF_LAST = 8'(OSV_PLL_HALF_CYC - 1);

	// Missing-edge window, counted in supervising-clock half periods.
	localparam int         OSV_WIN_TICKS = 4;
	localparam int         OSV_WIN_W     = 4;
	localparam logic [3:0] OSV_WIN_LAST  = 4'(OSV_WIN_TICKS - 1);

	// Register indices; the byte address is four times the index.
	localparam logic [15:0] OSV_IDX_IRQCTL = 16'hf19e;
	localparam logic [15:0] OSV_IDX_STATUS = 16'hf1a0;
	localparam logic [15:0] OSV_IDX_CFG    = 16'hf1a2;
	localparam logic [15:0] OSV_IDX_STATE  = 16'hf1a4;
	localparam int          OSV_AW         = 18;
	localparam logic [17:0] OSV_A_IRQCTL   = {OSV_IDX_IRQCTL, 2'b00};
	localparam logic [17:0] OSV_A_STATUS   = {OSV_IDX_STATUS, 2'b00};
	localparam logic [17:0] OSV_A_CFG      = {OSV_IDX_CFG, 2'b00};
	localparam logic [17:0] OSV_A_STATE    = {OSV_IDX_STATE, 2'b00};

	// Reset values and field positions.
	localparam logic [15:0] OSV_IRQCTL_RST = 16'h0000;
	localparam int          OSV_BIT_FAULT  = 0;
	localparam logic [2:0]  OSV_CFG_DIRECT = 3'h3;
	localparam logic [2:0]  OSV_CFG_PRESC  = 3'h1;
	localparam logic [2:0]  OSV_CFG_RST    = OSV_CFG_DIRECT;

	typedef enum logic [1:0] {
		OSV_SUP_OFF,
		OSV_SUP_WATCH,
		OSV_SUP_FAULT
	} osv_sup_t;

	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [17:0] addr;
		logic [31:0] wdata;
	} osv_apb_req_t;

	typedef struct packed {
		logic pll_running;
		logic sup_enabled;
		logic on_pll;
	} osv_state_t;

endpackage

// File: rtl/osv_tick_div.sv
// Divider that gives one-cycle ticks at the supervising clock's half period.
// Assumes the system clock of the package; stops and clears while run is low.
`timescale 1ns/1ps
module osv_tick_div import osv_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control and tick
	input  wire logic run,
	output logic      tick
);

	logic [OSV_DIV_W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == OSV_PLL_HALF_LAST) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			tick  <= 1'b0;
		end
	end

endmodule

// File: rtl/osv_oscillator_supervisor.sv
// Oscillator clock supervisor with fallback CPU clock and APB registers.
// Assumes oscillator and enable pin inputs are synchronous to CLK.
//
// Overview of operation
// - A missing oscillator edge flags a fault and raises the PLL/oscillator-fault interrupt.
// - On the fault the CPU clock source moves from the oscillator to the PLL clock.
// - While the fault lasts the PLL runs free at its base frequency.
// - In direct drive the fallback CPU clock is the undivided PLL base frequency.
// - In prescaler operation the fallback CPU clock is the PLL base frequency halved.
// - Only a hardware reset returns the CPU clock to the oscillator.
// - With the enable pin low and no fault latched the PLL idles and the CPU clock comes from the oscillator.
// - With supervision disabled a missing oscillator raises no interrupt.
// - An unconnected enable pin reads high through the pull-up, leaving supervision on.
// - Edges are watched with the PLL clock, which runs on when the oscillator stops.
// - A fault interrupt control register sits at index f19e with reset value zero.
// - Configuration code 001 selects the 2:1 prescaler.
`timescale 1ns/1ps
module osv_oscillator_supervisor import osv_pkg::*; (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	// APB slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [OSV_AW-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic [31:0]            PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// Oscillator and supervisor enable pin
	input  wire logic              OSC_IN,
	input  wire logic              SUP_EN_PIN_IN,
	input  wire logic              SUP_EN_PIN_FLOAT,
	// Clock outputs
	output logic                   CPU_CLK,
	output logic                   CPU_CLK_ON_PLL,
	output logic                   PLL_CLK,
	// Interrupt
	output logic                   IRQ
);

	osv_apb_req_t         req;
	osv_sup_t             state_r;
	osv_state_t           st;
	logic                 sup_en_r;
	logic                 osc_prev_r;
	logic                 osc_edge;
	logic                 osc_rise;
	logic                 pll_run;
	logic                 pll_tick;
	logic                 pll_ph_r;
	logic [OSV_WIN_W-1:0] win_r;
	logic                 missing;
	logic                 fault_evt;
	logic                 presc;
	logic                 cpu_clk_r;
	logic                 cpu_sel_r;
	logic [15:0]          irqctl_r;
	logic                 status_r;
	logic [2:0]           cfg_r;
	logic                 irq_r;
	logic [31:0]          prdata_r;
	logic                 pready_r;
	logic                 pslverr_r;
	logic [3:0]           hit;
	logic                 wr_acc;

	// One-hot register decode: irqctl, status, cfg, state.
	function automatic logic [3:0] reg_hit(input logic [OSV_AW-1:0] a);
		reg_hit = {a == OSV_A_STATE, a == OSV_A_CFG, a == OSV_A_STATUS, a == OSV_A_IRQCTL};
	endfunction

	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
	assign hit = reg_hit(req.addr);

	// The pad pull-up wins when nobody drives the pin.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sup_en_r <= 1'b1;
		end else begin
			sup_en_r <= SUP_EN_PIN_FLOAT | SUP_EN_PIN_IN;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			osc_prev_r <= 1'b0;
		end else begin
			osc_prev_r <= OSC_IN;
		end
	end

	assign osc_edge = OSC_IN ^ osc_prev_r;
	assign osc_rise = OSC_IN & ~osc_prev_r;

	// Once in fallback the PLL must keep running even if the pin later drops.
	assign pll_run = sup_en_r | (state_r == OSV_SUP_FAULT);

	osv_tick_div u_pll_div (
		.clk  (CLK),
		.rst  (SYS_RST),
		.run  (pll_run),
		.tick (pll_tick)
	);

	always_ff @(posedge CLK) begin
		if (SYS_RST || !pll_run) begin
			pll_ph_r <= 1'b0;
		end else if (pll_tick) begin
			pll_ph_r <= ~pll_ph_r;
		end
	end

	// The window is timed by PLL ticks, so a stopped oscillator still expires it.
	always_ff @(posedge CLK) begin
		if (SYS_RST || state_r != OSV_SUP_WATCH || osc_edge) begin
			win_r <= '0;
		end else if (pll_tick && win_r != OSV_WIN_LAST) begin
			win_r <= win_r + 4'h1;
		end
	end

	assign missing   = pll_tick && !osc_edge && win_r == OSV_WIN_LAST;
	assign fault_evt = state_r == OSV_SUP_WATCH && sup_en_r && missing;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_r <= OSV_SUP_OFF;
		end else begin
			case (state_r)
				OSV_SUP_OFF: begin
					if (sup_en_r) begin
						state_r <= OSV_SUP_WATCH;
					end
				end
				OSV_SUP_WATCH: begin
					if (!sup_en_r) begin
						state_r <= OSV_SUP_OFF;
					end else if (fault_evt) begin
						state_r <= OSV_SUP_FAULT;
					end
				end
				OSV_SUP_FAULT: begin
					state_r <= OSV_SUP_FAULT;
				end
				default: begin
					state_r <= OSV_SUP_OFF;
				end
			endcase
		end
	end

	assign presc = cfg_r == OSV_CFG_PRESC;

	// The source only changes while the CPU clock is low, so no phase is cut short.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cpu_sel_r <= 1'b0;
		end else if (state_r == OSV_SUP_FAULT && !cpu_clk_r) begin
			cpu_sel_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cpu_clk_r <= 1'b0;
		end else if (cpu_sel_r) begin
			if (pll_tick && (!presc || !pll_ph_r)) begin
				cpu_clk_r <= ~cpu_clk_r;
			end
		end else if (state_r == OSV_SUP_FAULT) begin
			// A stuck high phase is stretched to a PLL half period, never shortened.
			if (cpu_clk_r && pll_tick) begin
				cpu_clk_r <= 1'b0;
			end
		end else if (presc) begin
			if (osc_rise) begin
				cpu_clk_r <= ~cpu_clk_r;
			end
		end else begin
			cpu_clk_r <= OSC_IN;
		end
	end

	// APB: setup cycle loads the answer, access cycle completes with no wait state.
	assign wr_acc = req.sel && req.enable && pready_r && req.write;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (req.sel && !req.enable && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= hit == 4'h0;
			prdata_r  <= 32'h0000_0000;
			case (1'b1)
				hit[0]:  prdata_r <= {16'h0000, irqctl_r};
				hit[1]:  prdata_r <= {31'h0000_0000, status_r};
				hit[2]:  prdata_r <= {29'h0000_0000, cfg_r};
				hit[3]:  prdata_r <= {29'h0000_0000, st};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	assign st = '{pll_running: pll_run, sup_enabled: sup_en_r, on_pll: cpu_sel_r};

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irqctl_r <= OSV_IRQCTL_RST;
		end else if (wr_acc && hit[0]) begin
			irqctl_r <= req.wdata[15:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cfg_r <= OSV_CFG_RST;
		end else if (wr_acc && hit[2]) begin
			cfg_r <= req.wdata[2:0];
		end
	end

	// A fault in the same cycle as a write-one clear keeps the flag set.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			status_r <= 1'b0;
		end else if (fault_evt) begin
			status_r <= 1'b1;
		end else if (wr_acc && hit[1] && req.wdata[OSV_BIT_FAULT]) begin
			status_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= status_r & irqctl_r[OSV_BIT_FAULT];
		end
	end

	assign PRDATA         = prdata_r;
	assign PREADY         = pready_r;
	assign PSLVERR        = pslverr_r;
	assign CPU_CLK        = cpu_clk_r;
	assign CPU_CLK_ON_PLL = cpu_sel_r;
	assign PLL_CLK        = pll_ph_r;
	assign IRQ            = irq_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	chk_fault_sets_flag: assert property (
		fault_evt |=> status_r ##1 IRQ || !irqctl_r[OSV_BIT_FAULT])
		else $error("fault did not set status or interrupt");
	chk_switch_to_pll: assert property (
		state_r == OSV_SUP_FAULT && !cpu_clk_r && !cpu_sel_r |=> cpu_sel_r)
		else $error("cpu clock did not move to pll");
	chk_pll_free_run: assert property (pll_tick |=> !pll_tick [*8])
		else $error("pll tick spacing wrong");
	chk_direct_rate: assert property (
		cpu_sel_r && !presc && pll_tick |=> cpu_clk_r != $past(cpu_clk_r))
		else $error("direct fallback missed a toggle");
	chk_presc_rate: assert property (
		cpu_sel_r && presc && pll_tick && pll_ph_r |=> $stable(cpu_clk_r))
		else $error("prescaled fallback toggled too often");
	chk_fallback_sticky: assert property (cpu_sel_r |=> cpu_sel_r && state_r == OSV_SUP_FAULT)
		else $error("fallback left without reset");
	chk_pll_idle_off: assert property (!pll_run |=> !PLL_CLK)
		else $error("pll clock ran while idle");
	chk_no_irq_off: assert property ($rose(status_r) |-> $past(sup_en_r))
		else $error("fault flagged with supervision disabled");
	chk_pullup_level: assert property (SUP_EN_PIN_FLOAT |=> sup_en_r)
		else $error("floating enable pin did not read high");
	chk_window_expire: assert property (
		state_r == OSV_SUP_WATCH && sup_en_r && win_r == OSV_WIN_LAST && pll_tick && !osc_edge
		|=> state_r == OSV_SUP_FAULT)
		else $error("missing edge window did not expire");
	chk_glitch_free: assert property ($rose(cpu_sel_r) |-> !cpu_clk_r ##1 $stable(cpu_clk_r))
		else $error("source switch cut a clock phase");
	chk_apb_ready: assert property (PSEL && !PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer timing wrong");

	cov_fault_switch: cover property ($rose(cpu_sel_r));
	cov_irq_raised: cover property ($rose(IRQ));
	cov_presc_fallback: cover property (cpu_sel_r && presc && $rose(cpu_clk_r));
	cov_w1c_clear: cover property ($fell(status_r));

endmodule

// File: verif/osv_osc_model.sv
// Behavioural oscillator source driving the supervised oscillator input.
// Assumes the bench clock; the source toggles every half CLK cycles while run is high.
`timescale 1ns/1ps
module osv_osc_model (
	// Clock
	input  wire logic       clk,
	// Control
	input  wire logic       run,
	input  wire logic [3:0] half,
	// Oscillator output
	output logic            osc
);
	int cnt;

	initial begin
		osc = 1'b0;
		cnt = 0;
	end

	// A stopped crystal holds its last level, which is what the edge detector must catch.
	always @(posedge clk) begin
		if (run) begin
			if (cnt + 1 >= int'(half)) begin
				cnt <= 0;
				osc <= ~osc;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// File: verif/testbench.sv
// Self-checking bench of the oscillator clock supervisor.
// Assumes the design package and the oscillator model are compiled first.
`timescale 1ns/1ps
module testbench;
	import osv_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc;
	logic        run = 1'b1;
	logic [3:0]  half = 4'h3;
	logic        sup_in = 1'b1;
	logic        sup_float = 1'b0;
	logic        cpu_clk;
	logic        on_pll;
	logic        pll_clk;
	logic        irq;
	logic [33:0] note_q[$];
	logic [33:0] note;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          n;
	logic [31:0] rnd;
	logic [3:0]  h;
	logic        probe_pll = 1'b0;

	always #2.5 clk = ~clk;

	osv_osc_model osc_src (.clk(clk), .run(run), .half(half), .osc(osc));

	osv_oscillator_supervisor uut (
		.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .OSC_IN(osc), .SUP_EN_PIN_IN(sup_in),
		.SUP_EN_PIN_FLOAT(sup_float), .CPU_CLK(cpu_clk), .CPU_CLK_ON_PLL(on_pll),
		.PLL_CLK(pll_clk), .IRQ(irq)
	);

	task end_of_test();
		$display("Comparisons %0d, errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// The hang guard sits well above the thousand or so cycles the sequence needs.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("ERROR %0t timeout", $time);
			end_of_test();
		end
	end

	// Each answered transfer retires the oldest note: {check data, error, data}.
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			note = note_q.pop_front();
			comparisons++;
			if (pslverr !== note[32] || (note[33] && prdata !== note[31:0])) begin
				err_count++;
				$display("ERROR %0t apb addr %h data %h", $time, paddr, prdata);
			end
		end
	end

	task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
			input logic er);
		@(posedge clk);
		note_q.push_back({~wr, er, wr ? 32'h0000_0000 : d});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_irq();
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
			@(posedge clk);
	endtask

	// The clock being timed: the CPU clock, or the PLL clock while probe_pll is set.
	function automatic logic probe();
		probe = probe_pll ? pll_clk : cpu_clk;
	endfunction

	// Cycles between two changes of the probed clock.
	// The first two changes are skipped, since a mode switch just before the call can cut the first interval short.
	task automatic period(output int cnt);
		logic v;
		v = probe();
		for (int i = 0; i < 200 && probe() === v; i++)
			@(posedge clk);
		v = probe();
		for (int i = 0; i < 200 && probe() === v; i++)
			@(posedge clk);
		v = probe();
		cnt = 0;
		while (probe() === v && cnt < 200) begin
			@(posedge clk);
			cnt++;
		end
	endtask

	initial begin
		void'($urandom(32'h611c8297));
		do_reset();
		h = 4'(2 + $urandom % 6);
		half <= h;
		apb(1'b0, OSV_A_IRQCTL, 32'h0000_0000, 1'b0);
		apb(1'b0, OSV_A_CFG, 32'h0000_0003, 1'b0);
		apb(1'b0, OSV_A_STATE, 32'h0000_0006, 1'b0);
		apb(1'b0, 18'h3c6a0, 32'h0000_0000, 1'b1);
		rnd = $urandom;
		apb(1'b1, OSV_A_IRQCTL, rnd, 1'b0);
		apb(1'b0, OSV_A_IRQCTL, {16'h0000, rnd[15:0]}, 1'b0);
		apb(1'b1, OSV_A_IRQCTL, 32'h0000_0001, 1'b0);
		period(n);
		chk(32'(n), 32'(h));
		chk(32'(on_pll), 32'h0);
		run <= 1'b0;
		wait_irq();
		chk(32'(irq), 32'h1);
		// A CPU clock stuck high first waits for a PLL tick before the source moves.
		for (int i = 0; i < 40 && on_pll !== 1'b1; i++)
			@(posedge clk);
		chk(32'(on_pll), 32'h1);
		apb(1'b0, OSV_A_STATUS, 32'h0000_0001, 1'b0);
		apb(1'b0, OSV_A_STATE, 32'h0000_0007, 1'b0);
		period(n);
		chk(32'(n), 32'd20);
		probe_pll = 1'b1;
		period(n);
		chk(32'(n), 32'd20);
		probe_pll = 1'b0;
		run <= 1'b1;
		repeat (100) @(posedge clk);
		chk(32'(on_pll), 32'h1);
		apb(1'b1, OSV_A_IRQCTL, 32'h0000_0000, 1'b0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		apb(1'b1, OSV_A_STATUS, 32'h0000_0001, 1'b0);
		apb(1'b0, OSV_A_STATUS, 32'h0000_0000, 1'b0);
		do_reset();
		chk(32'(on_pll), 32'h0);
		apb(1'b1, OSV_A_CFG, 32'h0000_0001, 1'b0);
		period(n);
		chk(32'(n), 32'(2 * h));
		apb(1'b1, OSV_A_IRQCTL, 32'h0000_0001, 1'b0);
		run <= 1'b0;
		wait_irq();
		chk(32'(irq), 32'h1);
		period(n);
		chk(32'(n), 32'd40);
		run <= 1'b1;
		sup_in <= 1'b0;
		do_reset();
		apb(1'b1, OSV_A_IRQCTL, 32'h0000_0001, 1'b0);
		run <= 1'b0;
		repeat (300) @(posedge clk);
		chk(32'(irq), 32'h0);
		chk({30'h0, on_pll, pll_clk}, 32'h0);
		apb(1'b0, OSV_A_STATUS, 32'h0000_0000, 1'b0);
		run <= 1'b1;
		sup_float <= 1'b1;
		do_reset();
		apb(1'b1, OSV_A_IRQCTL, 32'h0000_0001, 1'b0);
		run <= 1'b0;
		wait_irq();
		chk(32'(irq), 32'h1);
		repeat (2) @(posedge clk);
		end_of_test();
	end
endmodule
